// ==== logic/tcc_pkg.sv ====
// Shared constants and types of the sixteen-bit counter core
`default_nettype none
package tcc_pkg;
	// ****************************************
	// I/O location map
	// ****************************************
	localparam logic [7:0] ADR_CTRL_FIRST = 8'h00; // Control register, first
	localparam logic [7:0] ADR_CTRL_SECOND = 8'h01; // Control register, second
	localparam logic [7:0] ADR_FLAGS = 8'h02; // Overflow flag, write one clears
	localparam logic [7:0] ADR_CNT_LO = 8'h04; // count_value_lower
	localparam logic [7:0] ADR_CNT_HI = 8'h05; // count_value_upper, via holding reg
	localparam logic [7:0] ADR_CAP_LO = 8'h06; // Capture value, low byte
	localparam logic [7:0] ADR_CAP_HI = 8'h07; // Capture value, high byte via holding
	localparam logic [7:0] ADR_CMPA_LO = 8'h08; // Compare A, low byte
	localparam logic [7:0] ADR_CMPA_HI = 8'h09; // Compare A, high byte read direct
	localparam logic [7:0] ADR_CMPB_LO = 8'h0A; // Compare B, low byte
	localparam logic [7:0] ADR_CMPB_HI = 8'h0B; // Compare B, high byte read direct

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int WGM_LO_POS = 0; // Mode bits 1:0 in first control register
	localparam int WGM_HI_POS = 3; // Mode bits 3:2 in second control register
	localparam int CS_POS = 0; // Clock select bits 2:0 in second control register
	localparam int OVF_POS = 0; // Overflow flag bit in flag register
	localparam logic [7:0] BYTE_RST = 8'h00; // Reset value of every byte register
	localparam logic [15:0] WORD_RST = 16'h0000; // Reset value of every word register

	// ****************************************
	// Count limits and clock selects
	// ****************************************
	localparam logic [15:0] CNT_MAX = 16'hFFFF; // Full-scale count
	localparam logic [15:0] CNT_FLOOR = 16'h0000; // Count_floor_indication of the count
	localparam logic [15:0] TOP_8BIT = 16'h00FF; // Fixed eight-bit top
	localparam logic [15:0] TOP_9BIT = 16'h01FF; // Fixed nine-bit top
	localparam logic [15:0] TOP_10BIT = 16'h03FF; // Fixed ten-bit top
	localparam logic [2:0] CS_STOP = 3'h0; // No timer clock
	localparam logic [2:0] CS_DIV1 = 3'h1; // System clock
	localparam logic [2:0] CS_DIV8 = 3'h2; // Divide by 8
	localparam logic [2:0] CS_DIV64 = 3'h3; // Divide by 64
	localparam logic [2:0] CS_DIV256 = 3'h4; // Divide by 256
	localparam logic [2:0] CS_DIV1024 = 3'h5; // Divide by 1024
	localparam logic [2:0] CS_EXT_FALL = 3'h6; // External pin, falling edge
	localparam logic [2:0] CS_EXT_RISE = 3'h7; // External pin, rising edge
	localparam logic [9:0] MASK_DIV8 = 10'h007; // Prescale tap masks
	localparam logic [9:0] MASK_DIV64 = 10'h03F;
	localparam logic [9:0] MASK_DIV256 = 10'h0FF;
	localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} tcc_dir_e; // Count direction

	typedef struct packed {
		logic rd; // Read strobe, one cycle
		logic wr; // Write strobe, one cycle
		logic [7:0] addr; // I/O location
		logic [7:0] wdata; // Write data
	} tcc_bus_s;
endpackage : tcc_pkg
`default_nettype wire

// ==== logic/tcc_clk_select.sv ====
// Timer clock selection: prescaler taps and external edge
`timescale 1ns/1ps
`default_nettype none
module tcc_clk_select #(
	parameter int PRE_W = 10 // Prescaler width, must reach 1024
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [2:0] clock_source_select,
	input wire logic ext_clk_pin,
	output logic timer_tick
);
	// ****************************************
	// Elaboration check
	// ****************************************
	if (PRE_W < 10) begin : g_bad_width
		$error("tcc_clk_select: PRE_W below 10");
	end

	logic [PRE_W-1:0] pre_ff; // Free running prescaler
	logic [PRE_W-1:0] nxt_pre_ff;
	logic ext_prev_ff; // Last sample of the external pin
	logic nxt_ext_prev_ff;
	logic tick_ff; // Registered timer tick
	logic nxt_tick_ff;

	// Tap test: all low bits of the prescaler set
	function automatic logic tap_hit(input logic [9:0] pre, input logic [9:0] mask);
		tap_hit = ((pre & mask) == mask);
	endfunction : tap_hit

	// ****************************************
	// Next tick from the selected source
	// ****************************************
	always_comb begin
		nxt_pre_ff = pre_ff + 1'b1;
		nxt_ext_prev_ff = ext_clk_pin;
		case (clock_source_select) // R7
			tcc_pkg::CS_STOP: nxt_tick_ff = 1'b0; // R11
			tcc_pkg::CS_DIV1: nxt_tick_ff = 1'b1;
			tcc_pkg::CS_DIV8: nxt_tick_ff = tap_hit(pre_ff[9:0], tcc_pkg::MASK_DIV8);
			tcc_pkg::CS_DIV64: nxt_tick_ff = tap_hit(pre_ff[9:0], tcc_pkg::MASK_DIV64);
			tcc_pkg::CS_DIV256: nxt_tick_ff = tap_hit(pre_ff[9:0], tcc_pkg::MASK_DIV256);
			tcc_pkg::CS_DIV1024: nxt_tick_ff = tap_hit(pre_ff[9:0], tcc_pkg::MASK_DIV1024);
			tcc_pkg::CS_EXT_FALL: nxt_tick_ff = ext_prev_ff & ~ext_clk_pin;
			tcc_pkg::CS_EXT_RISE: nxt_tick_ff = ~ext_prev_ff & ext_clk_pin;
			default: nxt_tick_ff = 1'b0;
		endcase
	end

	// Register stage
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pre_ff <= '0;
			ext_prev_ff <= 1'b0;
			tick_ff <= 1'b0;
		end else begin
			pre_ff <= nxt_pre_ff;
			ext_prev_ff <= nxt_ext_prev_ff;
			tick_ff <= nxt_tick_ff;
		end
	end

	assign timer_tick = tick_ff;
endmodule : tcc_clk_select
`default_nettype wire

// ==== logic/tcc_count_step.sv ====
// Count sequencer: next count, direction, top and overflow event
`timescale 1ns/1ps
`default_nettype none
module tcc_count_step (
	input wire logic [15:0] cnt,
	input wire tcc_pkg::tcc_dir_e dir,
	input wire logic [3:0] waveform_mode_field,
	input wire logic [15:0] cmpa,
	input wire logic [15:0] cap,
	input wire logic timer_tick,
	output logic [15:0] nxt_cnt,
	output tcc_pkg::tcc_dir_e nxt_dir,
	output logic ovf_evt,
	output logic [15:0] top_val
);
	logic dual; // Up-down sequence
	logic ovf_at_max; // Modes 4 and C flag overflow at full scale

	// ****************************************
	// Top and sequence by mode
	// ****************************************
	always_comb begin
		case (waveform_mode_field) // R14
			4'h0: top_val = tcc_pkg::CNT_MAX;
			4'h1, 4'h5: top_val = tcc_pkg::TOP_8BIT;
			4'h2, 4'h6: top_val = tcc_pkg::TOP_9BIT;
			4'h3, 4'h7: top_val = tcc_pkg::TOP_10BIT;
			4'h4, 4'h9, 4'hB, 4'hF: top_val = cmpa;
			4'h8, 4'hA, 4'hC, 4'hE: top_val = cap;
			default: top_val = tcc_pkg::CNT_MAX;
		endcase
		dual = (waveform_mode_field inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
		ovf_at_max = (waveform_mode_field == 4'h4) || (waveform_mode_field == 4'hC);
	end

	// ****************************************
	// One step per tick
	// ****************************************
	always_comb begin
		nxt_cnt = cnt;
		nxt_dir = dir;
		ovf_evt = 1'b0;
		if (timer_tick) begin // R10
			if (dual) begin
				// Turn at top going up, at count_floor_indication going down
				ovf_evt = (cnt == tcc_pkg::CNT_FLOOR); // R15
				if (dir == tcc_pkg::DIR_UP && cnt >= top_val) begin
					nxt_dir = tcc_pkg::DIR_DOWN;
					nxt_cnt = cnt - 16'h0001; // R8
				end else if (dir == tcc_pkg::DIR_DOWN && cnt == tcc_pkg::CNT_FLOOR) begin
					nxt_dir = tcc_pkg::DIR_UP;
					nxt_cnt = cnt + 16'h0001;
				end else if (dir == tcc_pkg::DIR_DOWN) begin
					nxt_cnt = cnt - 16'h0001;
				end else begin
					nxt_cnt = cnt + 16'h0001;
				end
			end else begin
				nxt_dir = tcc_pkg::DIR_UP;
				ovf_evt = ovf_at_max ? (cnt == tcc_pkg::CNT_MAX) : (cnt == top_val);
				nxt_cnt = (cnt == top_val) ? tcc_pkg::CNT_FLOOR : cnt + 16'h0001; // R8
			end
		end
	end
endmodule : tcc_count_step
`default_nettype wire

// ==== logic/tcc_core.sv ====
// Sixteen-bit counter core with shared high-byte holding register
//
// Functional notes
// (R1) Counter seen as upper and lower byte
// (R2) Upper-byte access reaches holding register only
// (R3) Low read captures high; low write loads
// (R4) Whole sixteen bits move in one cycle
// (R5) Software masks interrupts around two-byte access
// (R6) Software may reuse one loaded high byte
// (R7) Three-bit select picks timer clock source
// (R8) Count steps by one; clear zeroes all
// (R9) Top and count_floor_indication indications from count
// (R10) Mode decides clear, increment or decrement
// (R11) Select zero stops clock, count holds
// (R12) CPU access works with clock stopped
// (R13) CPU write beats same-cycle count or clear
// (R14) Four-bit mode field split over controls
// (R15) Overflow flag set at mode-defined point
// (R16) Software avoids risky writes while counting
// (R17) One holding register for all words
// (R18) Write high first; read low first
// (R19) Compare high byte read directly
// (R20) Reset zeroes counter, holding, clock select
`timescale 1ns/1ps
`default_nettype none
module tcc_core #(
	parameter int CNT_W = 16 // Counter width, fixed by byte map
) (
	input wire logic clk,
	input wire logic nrst,
	input wire tcc_pkg::tcc_bus_s io_req,
	input wire logic ext_clk_pin,
	output logic [7:0] io_rdata_ff,
	output logic overflow_flag_ff,
	output logic count_top_ff,
	output logic count_floor_indication_ff
);
	// ****************************************
	// Elaboration check
	// ****************************************
	if (CNT_W != 16) begin : g_bad_width
		$error("tcc_core: CNT_W must be 16");
	end

	// ****************************************
	// State
	// ****************************************
	logic [15:0] count_value_ff; // The counter
	logic [15:0] nxt_count_value_ff;
	logic [7:0] hold_ff; // Shared high-byte holding register
	logic [7:0] nxt_hold_ff;
	logic [15:0] cmpa_ff; // Compare A
	logic [15:0] nxt_cmpa_ff;
	logic [15:0] cmpb_ff; // Compare B
	logic [15:0] nxt_cmpb_ff;
	logic [15:0] cap_ff; // Capture value
	logic [15:0] nxt_cap_ff;
	logic [7:0] ctrl_first_ff; // control_reg_first
	logic [7:0] nxt_ctrl_first_ff;
	logic [7:0] ctrl_second_ff; // control_reg_second
	logic [7:0] nxt_ctrl_second_ff;
	tcc_pkg::tcc_dir_e dir_ff; // Count direction
	tcc_pkg::tcc_dir_e nxt_dir_ff;
	logic nxt_overflow_flag_ff;
	logic [7:0] nxt_io_rdata_ff;
	logic nxt_count_top_ff;
	logic nxt_count_floor_ff;

	// ****************************************
	// Decoded fields and helpers
	// ****************************************
	logic [2:0] clock_source_select; // Clock select field
	logic [3:0] waveform_mode_field; // Mode field, two halves
	logic timer_tick; // One-cycle count enable
	logic [15:0] step_cnt; // Counter after this tick
	tcc_pkg::tcc_dir_e step_dir; // Direction after this tick
	logic step_ovf; // Overflow point reached
	logic [15:0] top_val; // Top for the mode
	logic cnt_wr; // Low-byte write to the counter

	assign clock_source_select = ctrl_second_ff[tcc_pkg::CS_POS +: 3]; // R7
	assign waveform_mode_field = {ctrl_second_ff[tcc_pkg::WGM_HI_POS +: 2],
		ctrl_first_ff[tcc_pkg::WGM_LO_POS +: 2]}; // R14
	assign cnt_wr = io_req.wr && (io_req.addr == tcc_pkg::ADR_CNT_LO);

	// Access decode for one location
	function automatic logic hit(input tcc_pkg::tcc_bus_s r, input logic [7:0] a, input logic w);
		hit = (w ? r.wr : r.rd) && (r.addr == a);
	endfunction : hit

	// ****************************************
	// Submodules
	// ****************************************
	tcc_clk_select #(.PRE_W(10)) u_clk_select (
		.clk(clk),
		.nrst(nrst),
		.clock_source_select(clock_source_select),
		.ext_clk_pin(ext_clk_pin),
		.timer_tick(timer_tick)
	);

	tcc_count_step u_count_step (
		.cnt(count_value_ff),
		.dir(dir_ff),
		.waveform_mode_field(waveform_mode_field),
		.cmpa(cmpa_ff),
		.cap(cap_ff),
		.timer_tick(timer_tick),
		.nxt_cnt(step_cnt),
		.nxt_dir(step_dir),
		.ovf_evt(step_ovf),
		.top_val(top_val)
	);

	// ****************************************
	// Next values of counter and registers
	// ****************************************
	always_comb begin
		nxt_hold_ff = hold_ff;
		nxt_cmpa_ff = cmpa_ff;
		nxt_cmpb_ff = cmpb_ff;
		nxt_cap_ff = cap_ff;
		nxt_ctrl_first_ff = ctrl_first_ff;
		nxt_ctrl_second_ff = ctrl_second_ff;
		// Count path, CPU write overrides below
		nxt_count_value_ff = step_cnt; // R10
		nxt_dir_ff = step_dir;
		nxt_overflow_flag_ff = overflow_flag_ff;
		// Flag clear by writing one; a same-cycle set wins
		if (hit(io_req, tcc_pkg::ADR_FLAGS, 1'b1) && io_req.wdata[tcc_pkg::OVF_POS]) begin
			nxt_overflow_flag_ff = 1'b0;
		end
		if (cnt_wr) begin
			// Holding byte and written byte land together
			nxt_count_value_ff = {hold_ff, io_req.wdata}; // R3 R4 R13
			nxt_dir_ff = dir_ff;
		end else if (step_ovf) begin
			nxt_overflow_flag_ff = 1'b1; // R15
		end
		// High-byte writes all land in the one holding register
		if (hit(io_req, tcc_pkg::ADR_CNT_HI, 1'b1) || hit(io_req, tcc_pkg::ADR_CAP_HI, 1'b1)
			|| hit(io_req, tcc_pkg::ADR_CMPA_HI, 1'b1) || hit(io_req, tcc_pkg::ADR_CMPB_HI, 1'b1)) begin
			nxt_hold_ff = io_req.wdata; // R2 R17
		end
		// Low-byte reads that fill the holding register
		if (hit(io_req, tcc_pkg::ADR_CNT_LO, 1'b0)) begin
			nxt_hold_ff = count_value_ff[15:8]; // R3
		end else if (hit(io_req, tcc_pkg::ADR_CAP_LO, 1'b0)) begin
			nxt_hold_ff = cap_ff[15:8]; // R17
		end
		// Low-byte writes of the other words
		if (hit(io_req, tcc_pkg::ADR_CMPA_LO, 1'b1)) begin
			nxt_cmpa_ff = {hold_ff, io_req.wdata}; // R17
		end
		if (hit(io_req, tcc_pkg::ADR_CMPB_LO, 1'b1)) begin
			nxt_cmpb_ff = {hold_ff, io_req.wdata};
		end
		if (hit(io_req, tcc_pkg::ADR_CAP_LO, 1'b1)) begin
			nxt_cap_ff = {hold_ff, io_req.wdata};
		end
		if (hit(io_req, tcc_pkg::ADR_CTRL_FIRST, 1'b1)) begin
			nxt_ctrl_first_ff = io_req.wdata;
		end
		if (hit(io_req, tcc_pkg::ADR_CTRL_SECOND, 1'b1)) begin
			nxt_ctrl_second_ff = io_req.wdata;
		end
		// Indications follow the counter register
		nxt_count_top_ff = (nxt_count_value_ff == top_val); // R9
		nxt_count_floor_ff = (nxt_count_value_ff == tcc_pkg::CNT_FLOOR); // R9
	end

	// ****************************************
	// Read data, registered one cycle after the strobe
	// ****************************************
	always_comb begin
		nxt_io_rdata_ff = io_rdata_ff;
		if (io_req.rd) begin
			case (io_req.addr) // R1 R12
				tcc_pkg::ADR_CTRL_FIRST: nxt_io_rdata_ff = ctrl_first_ff;
				tcc_pkg::ADR_CTRL_SECOND: nxt_io_rdata_ff = ctrl_second_ff;
				tcc_pkg::ADR_FLAGS: nxt_io_rdata_ff = {7'h00, overflow_flag_ff};
				tcc_pkg::ADR_CNT_LO: nxt_io_rdata_ff = count_value_ff[7:0];
				tcc_pkg::ADR_CNT_HI: nxt_io_rdata_ff = hold_ff; // R2
				tcc_pkg::ADR_CAP_LO: nxt_io_rdata_ff = cap_ff[7:0];
				tcc_pkg::ADR_CAP_HI: nxt_io_rdata_ff = hold_ff;
				tcc_pkg::ADR_CMPA_LO: nxt_io_rdata_ff = cmpa_ff[7:0];
				tcc_pkg::ADR_CMPA_HI: nxt_io_rdata_ff = cmpa_ff[15:8]; // R19
				tcc_pkg::ADR_CMPB_LO: nxt_io_rdata_ff = cmpb_ff[7:0];
				tcc_pkg::ADR_CMPB_HI: nxt_io_rdata_ff = cmpb_ff[15:8]; // R19
				default: nxt_io_rdata_ff = tcc_pkg::BYTE_RST;
			endcase
		end
	end

	// ****************************************
	// Register stage
	// ****************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			count_value_ff <= tcc_pkg::WORD_RST; // R20
			hold_ff <= tcc_pkg::BYTE_RST; // R20
			ctrl_second_ff <= tcc_pkg::BYTE_RST; // R20
			ctrl_first_ff <= tcc_pkg::BYTE_RST;
			cmpa_ff <= tcc_pkg::WORD_RST;
			cmpb_ff <= tcc_pkg::WORD_RST;
			cap_ff <= tcc_pkg::WORD_RST;
			dir_ff <= tcc_pkg::DIR_UP;
			overflow_flag_ff <= 1'b0;
			io_rdata_ff <= tcc_pkg::BYTE_RST;
			count_top_ff <= 1'b0;
			count_floor_indication_ff <= 1'b1;
		end else begin
			count_value_ff <= nxt_count_value_ff;
			hold_ff <= nxt_hold_ff;
			ctrl_second_ff <= nxt_ctrl_second_ff;
			ctrl_first_ff <= nxt_ctrl_first_ff;
			cmpa_ff <= nxt_cmpa_ff;
			cmpb_ff <= nxt_cmpb_ff;
			cap_ff <= nxt_cap_ff;
			dir_ff <= nxt_dir_ff;
			overflow_flag_ff <= nxt_overflow_flag_ff;
			io_rdata_ff <= nxt_io_rdata_ff;
			count_top_ff <= nxt_count_top_ff;
			count_floor_indication_ff <= nxt_count_floor_ff;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_reset_zero: assert property ($rose(nrst) |-> count_value_ff == 16'h0000 && hold_ff == 8'h00
		&& clock_source_select == 3'h0) else $error("reset state not zero"); // R20
	a_stop_no_tick: assert property (clock_source_select == 3'h0 |=> !timer_tick)
		else $error("tick while stopped"); // R11
	a_stop_holds: assert property (clock_source_select == 3'h0 && !cnt_wr ##1 !cnt_wr
		|=> $stable(count_value_ff)) else $error("count moved while stopped"); // R11
	a_write_wins: assert property (cnt_wr |=> count_value_ff == {$past(hold_ff), $past(io_req.wdata)})
		else $error("counter write lost"); // R13
	a_low_read_cap: assert property (hit(io_req, 8'h04, 1'b0) |=> hold_ff == $past(count_value_ff[15:8])
		&& io_rdata_ff == $past(count_value_ff[7:0])) else $error("low read not atomic"); // R3
	a_high_via_hold: assert property (hit(io_req, 8'h05, 1'b0) |=> io_rdata_ff == $past(hold_ff))
		else $error("high read bypassed holding"); // R2
	a_cmp_high_direct: assert property (hit(io_req, 8'h09, 1'b0) && !io_req.wr |=> io_rdata_ff == $past(cmpa_ff[15:8])
		&& $stable(hold_ff)) else $error("compare high read wrong"); // R19
	a_shared_hold: assert property (hit(io_req, 8'h0B, 1'b1) |=> hold_ff == $past(io_req.wdata))
		else $error("holding not shared"); // R17
	a_step_by_one: assert property (timer_tick && !cnt_wr && waveform_mode_field == 4'h0
		|=> count_value_ff == $past(count_value_ff) + 16'h0001) else $error("count step wrong"); // R8
	a_ovf_sticky: assert property (overflow_flag_ff && !hit(io_req, 8'h02, 1'b1) |=> overflow_flag_ff)
		else $error("overflow flag dropped"); // R15
	a_floor_tracks: assert property (count_floor_indication_ff == (count_value_ff == 16'h0000))
		else $error("floor indication wrong"); // R9

	c_wrap: cover property (overflow_flag_ff && waveform_mode_field == 4'h0);
	c_word_write: cover property (hit(io_req, 8'h05, 1'b1) ##1 cnt_wr);
	c_word_read: cover property (hit(io_req, 8'h04, 1'b0) ##1 hit(io_req, 8'h05, 1'b0));
	c_turn_down: cover property (dir_ff == tcc_pkg::DIR_DOWN);
endmodule : tcc_core
`default_nettype wire

// ==== verification/tcc_cpu_model.sv ====
// CPU-side bus master model driving the counter core's byte-wide I/O bus
`timescale 1ns/1ps
`default_nettype none
module tcc_cpu_model (
	input wire logic clk,
	output var tcc_pkg::tcc_bus_s io_req,
	input wire logic [7:0] io_rdata
);
	// ****************************************
	// Single byte access
	// ****************************************
	// Idle bus at time zero
	initial begin
		io_req = '0;
	end

	// Request at a falling edge, taken at the next rising edge, released one cycle later
	task automatic access(input logic rd_en, input logic wr_en, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk);
		io_req <= '{rd: rd_en, wr: wr_en, addr: a, wdata: d};
		@(negedge clk);
		q = io_rdata;
		// Released strobes drop; address and data show the inverse, never a stale value
		io_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask : access

	// Byte write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		access(1'b0, 1'b1, a, d, q);
	endtask : wr

	// Byte read
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		access(1'b1, 1'b0, a, 8'h00, q);
	endtask : rd

	// ****************************************
	// Word access through the holding byte
	// ****************************************
	// Upper byte first, then lower; no other access in between
	task automatic wr_word(input logic [7:0] lo, input logic [15:0] v);
		wr(lo + 8'h01, v[15:8]);
		wr(lo, v[7:0]);
	endtask : wr_word

	// Lower byte first, then upper; no other access in between
	task automatic rd_word(input logic [7:0] lo, output logic [15:0] v);
		rd(lo, v[7:0]);
		rd(lo + 8'h01, v[15:8]);
	endtask : rd_word
endmodule : tcc_cpu_model
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking testbench of the sixteen-bit counter core
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk; // System clock
	logic nrst; // Synchronous reset, active low
	logic ext_clk_pin; // External count source
	tcc_pkg::tcc_bus_s io_req; // Bus from the CPU model
	logic [7:0] io_rdata_ff; // Read data
	logic overflow_flag_ff; // Sticky overflow
	logic count_top_ff; // Top indication
	logic count_floor_indication_ff; // Zero indication
	int errors; // Mismatch count
	int total_checks; // Comparison count
	int cyc; // Cycles since start
	logic [3:0] md; // Mode in use
	logic [15:0] w; // Word read back
	logic [7:0] b; // Byte read back

	tcc_core dut_u (.clk(clk), .nrst(nrst), .io_req(io_req), .ext_clk_pin(ext_clk_pin),
		.io_rdata_ff(io_rdata_ff), .overflow_flag_ff(overflow_flag_ff), .count_top_ff(count_top_ff),
		.count_floor_indication_ff(count_floor_indication_ff));
	tcc_cpu_model cpu_u (.clk(clk), .io_req(io_req), .io_rdata(io_rdata_ff));

	// ****************************************
	// Clock, timeout and reporting
	// ****************************************
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Cut a hang short well past the expected run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			$display("unexpected at %0t: run timed out", $time);
			end_sim();
		end
	end

	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// Verdict and end of run
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	// ****************************************
	// Helpers
	// ****************************************
	// Mode written over both control registers, clock stopped
	task automatic set_mode(input logic [3:0] m);
		md = m;
		cpu_u.wr(tcc_pkg::ADR_CTRL_FIRST, {6'h00, m[1:0]});
		cpu_u.wr(tcc_pkg::ADR_CTRL_SECOND, {3'h0, m[3:2], tcc_pkg::CS_STOP});
	endtask : set_mode

	// Start a source, wait r cycles, stop; system clock gives r+2 ticks
	task automatic run(input logic [2:0] cs, input int r);
		cpu_u.wr(tcc_pkg::ADR_CTRL_SECOND, {3'h0, md[3:2], cs});
		repeat (r) @(negedge clk);
		cpu_u.wr(tcc_pkg::ADR_CTRL_SECOND, {3'h0, md[3:2], tcc_pkg::CS_STOP});
		repeat (3) @(negedge clk);
	endtask : run

	// ****************************************
	// Scenarios
	// ****************************************
	// Reset state: stopped, zero, holding byte clear
	task automatic t_reset();
		cpu_u.rd(tcc_pkg::ADR_CNT_HI, b);
		check({8'h00, b}, 16'h0000, "holding after reset");
		cpu_u.rd_word(tcc_pkg::ADR_CNT_LO, w);
		check(w, tcc_pkg::WORD_RST, "count after reset");
		cpu_u.rd(tcc_pkg::ADR_CTRL_SECOND, b);
		check({8'h00, b}, 16'h0000, "select after reset");
		check({15'h0, count_floor_indication_ff}, 16'h0001, "floor after reset");
		check({14'h0, count_top_ff, overflow_flag_ff}, 16'h0000, "top and flag after reset");
		$display("test reset done");
	endtask : t_reset

	// Word write and read of the counter through the holding byte
	task automatic t_word();
		cpu_u.wr_word(tcc_pkg::ADR_CNT_LO, 16'h01FF);
		cpu_u.rd_word(tcc_pkg::ADR_CNT_LO, w);
		check(w, 16'h01FF, "word write then read");
		repeat (20) @(negedge clk);
		cpu_u.wr(tcc_pkg::ADR_CNT_HI, 8'h77);
		cpu_u.rd(tcc_pkg::ADR_CNT_HI, b);
		check({8'h00, b}, 16'h0077, "upper reads holding");
		cpu_u.rd_word(tcc_pkg::ADR_CNT_LO, w);
		check(w, 16'h01FF, "count held while stopped");
		cpu_u.rd(8'h03, b);
		check({8'h00, b}, 16'h0000, "unmapped read");
		$display("test word done");
	endtask : t_word

	// One holding byte shared by every word; compare upper read direct
	task automatic t_shared();
		cpu_u.wr_word(tcc_pkg::ADR_CMPA_LO, 16'h1234);
		cpu_u.wr(tcc_pkg::ADR_CNT_HI, 8'hAB);
		cpu_u.rd(tcc_pkg::ADR_CMPA_HI, b);
		check({8'h00, b}, 16'h0012, "compare upper direct");
		cpu_u.wr(tcc_pkg::ADR_CNT_LO, 8'h56);
		cpu_u.wr(tcc_pkg::ADR_CMPB_LO, 8'h78);
		cpu_u.rd_word(tcc_pkg::ADR_CNT_LO, w);
		check(w, 16'hAB56, "count with reused upper");
		cpu_u.rd(tcc_pkg::ADR_CMPB_HI, b);
		check({8'h00, b}, 16'h00AB, "second compare upper");
		$display("test shared done");
	endtask : t_shared

	// Modes: wrap and overflow, clear at compare top, fixed eight-bit top
	task automatic t_modes();
		set_mode(4'h0);
		cpu_u.wr_word(tcc_pkg::ADR_CNT_LO, 16'hFFF8);
		run(tcc_pkg::CS_DIV1, 10);
		cpu_u.rd_word(tcc_pkg::ADR_CNT_LO, w);
		check(w, 16'h0004, "mode 0 wrap");
		check({15'h0, overflow_flag_ff}, 16'h0001, "overflow set");
		cpu_u.wr(tcc_pkg::ADR_FLAGS, 8'h01);
		check({15'h0, overflow_flag_ff}, 16'h0000, "overflow cleared");
		set_mode(4'h4);
		cpu_u.wr_word(tcc_pkg::ADR_CMPA_LO, 16'h0005);
		cpu_u.wr_word(tcc_pkg::ADR_CNT_LO, 16'h0000);
		run(tcc_pkg::CS_DIV1, 10);
		cpu_u.rd_word(tcc_pkg::ADR_CNT_LO, w);
		check(w, 16'h0000, "clear at compare top");
		check({15'h0, count_floor_indication_ff}, 16'h0001, "floor at zero");
		check({15'h0, overflow_flag_ff}, 16'h0000, "no overflow below max");
		set_mode(4'h5);
		cpu_u.wr_word(tcc_pkg::ADR_CNT_LO, 16'h00F0);
		run(tcc_pkg::CS_DIV1, 13);
		check({15'h0, count_top_ff}, 16'h0001, "top at 00FF");
		cpu_u.rd_word(tcc_pkg::ADR_CNT_LO, w);
		check(w, 16'h00FF, "eight bit top value");
		$display("test modes done");
	endtask : t_modes

	// CPU write lands even while a tick falls in the same cycle
	task automatic t_write_wins();
		set_mode(4'h0);
		cpu_u.wr(tcc_pkg::ADR_CTRL_SECOND, {3'h0, 2'h0, tcc_pkg::CS_DIV1});
		cpu_u.wr_word(tcc_pkg::ADR_CNT_LO, 16'h0100);
		cpu_u.wr(tcc_pkg::ADR_CTRL_SECOND, {3'h0, 2'h0, tcc_pkg::CS_STOP});
		repeat (3) @(negedge clk);
		cpu_u.rd_word(tcc_pkg::ADR_CNT_LO, w);
		check(w, 16'h0103, "write over running count");
		$display("test write priority done");
	endtask : t_write_wins

	// Clock selects 1 to 7: prescaler taps by range, external edges exactly
	task automatic t_sources();
		int div;
		for (int cs = 1; cs <= 5; cs++) begin
			div = (cs == 1) ? 1 : (cs == 2) ? 8 : (cs == 3) ? 64 : (cs == 4) ? 256 : 1024;
			cpu_u.wr_word(tcc_pkg::ADR_CNT_LO, 16'h0000);
			run(cs[2:0], 2048);
			cpu_u.rd_word(tcc_pkg::ADR_CNT_LO, w);
			check({15'h0, (w >= 16'(2050 / div)) && (w <= 16'(2050 / div + 1))}, 16'h0001, "prescaled ticks");
		end
		for (int cs = 6; cs <= 7; cs++) begin
			cpu_u.wr_word(tcc_pkg::ADR_CNT_LO, 16'h0000);
			cpu_u.wr(tcc_pkg::ADR_CTRL_SECOND, {5'h00, cs[2:0]});
			repeat (4) begin
				@(negedge clk) ext_clk_pin = 1'b1;
				repeat (3) @(negedge clk);
				ext_clk_pin = 1'b0;
				repeat (2) @(negedge clk);
			end
			repeat (3) @(negedge clk);
			cpu_u.wr(tcc_pkg::ADR_CTRL_SECOND, {5'h00, tcc_pkg::CS_STOP});
			cpu_u.rd_word(tcc_pkg::ADR_CNT_LO, w);
			check(w, 16'h0004, "external edges");
		end
		$display("test sources done");
	endtask : t_sources

	// Dual slope turning at a capture top; holding byte reached through compare B upper
	task automatic t_dual();
		set_mode(4'h8);
		cpu_u.wr(tcc_pkg::ADR_FLAGS, 8'h01);
		cpu_u.wr(tcc_pkg::ADR_CMPB_HI, 8'h00);
		cpu_u.wr(tcc_pkg::ADR_CAP_LO, 8'h03);
		cpu_u.rd_word(tcc_pkg::ADR_CAP_LO, w);
		check(w, 16'h0003, "capture via shared holding");
		cpu_u.wr_word(tcc_pkg::ADR_CNT_LO, 16'h0002);
		run(tcc_pkg::CS_DIV1, 4);
		cpu_u.rd_word(tcc_pkg::ADR_CNT_LO, w);
		check(w, 16'h0002, "dual slope turn");
		check({15'h0, overflow_flag_ff}, 16'h0001, "overflow at count_floor_indication");
		$display("test dual done");
	endtask : t_dual

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		errors = 0;
		total_checks = 0;
		cyc = 0;
		md = 4'h0;
		nrst = 1'b0;
		ext_clk_pin = 1'b0;
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		t_reset();
		t_word();
		t_shared();
		t_modes();
		t_write_wins();
		t_sources();
		t_dual();
		end_sim();
	end
endmodule : tb
`default_nettype wire
